// >>> hw/rgc_pkg.sv
// Package for the receiver gain control block: register map, field
// positions, reset values, state codes and carrier structs.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
package rgc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LNA_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CURRENT_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_RX_CTRL = 8'h08;
  localparam logic [7:0] ADDR_SS_THRESHOLD = 8'h0c;
  localparam logic [7:0] ADDR_REARM_DELAY = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_BAND_THR_BASE = 8'h18;
  localparam logic [7:0] ADDR_BAND_THR_LAST = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LNA_ZIN_BIT = 0;
  localparam int LNA_SEL_LSB = 1;
  localparam int LNA_APPLIED_LSB = 4;
  localparam int LIMIT_MA_LSB = 8;
  localparam int CTRL_RX_EN_BIT = 0;
  localparam int CTRL_CONT_BIT = 1;
  localparam int CTRL_AUTO_BIT = 2;
  localparam int CTRL_REARM_BIT = 3;
  localparam int STAT_STATE_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [3:0] TRIM_RESET = 4'ha;
  localparam logic [7:0] SS_THRESHOLD_RESET = 8'he4;
  localparam logic [15:0] REARM_DELAY_RESET = 16'h0000;
  localparam logic [7:0] LIMIT_BASE_MA = 8'h2d;
  localparam logic [7:0] LIMIT_STEP_MA = 8'h05;
  localparam logic [1:0] HITS_NEEDED = 2'h2;
  localparam int NUM_BANDS = 5;
  localparam logic [7:0] BAND_THR_RESET_STEP = 8'h30;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Gain select codes
  localparam logic [2:0] GAIN_AUTO = 3'h0;
  localparam logic [2:0] GAIN_STEP_1 = 3'h1;
  localparam logic [2:0] GAIN_STEP_6 = 3'h6;
  localparam logic [2:0] GAIN_RESERVED = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_DELAY = 4'b1000
  } rgc_state_type;

  typedef struct packed {
    logic valid;
    logic [7:0] strength;
  } rgc_sample_type;

  typedef struct packed {
    logic waiting;
    logic locked;
    logic [2:0] gain_step;
  } rgc_status_type;

endpackage

// >>> hw/rgc_gain_band.sv
// Maps a signal strength sample onto one of six gain steps by
// comparing it with five ascending band thresholds.
// Assumes thresholds are programmed in ascending order.
`timescale 1ns/1ps
module rgc_gain_band #(
  parameter int BANDS = 5,
  parameter int WIDTH = 8
) (
  // Sample and thresholds
  input wire logic [WIDTH-1:0] strength_i,
  input wire logic [BANDS*WIDTH-1:0] thresholds_i,
  // Chosen step code
  output logic [2:0] step_code_o
);
  import rgc_pkg::*;

  // ----------------------------------------------------------------
  // Band compare
  // ----------------------------------------------------------------
  logic [BANDS-1:0] above;

  genvar g;
  generate
    for (g = 0; g < BANDS; g++) begin : gen_cmp
      assign above[g] = strength_i > thresholds_i[g*WIDTH +: WIDTH];
    end
  endgenerate

  // Count of thresholds passed; stronger input picks a lower gain
  always_comb begin
    step_code_o = GAIN_STEP_1;
    for (int i = 0; i < BANDS; i++) begin
      if (above[i]) begin
        step_code_o = GAIN_STEP_1 + 3'(i + 1);
      end
    end
  end

endmodule

// >>> hw/rgc_agc_top.sv
// Top of the receiver gain control block with its AXI4-Lite slave.
// Assumes samples, packet-done pulses and FIFO status are synchronous
// to clk_i.
`timescale 1ns/1ps
module rgc_agc_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axil_awaddr_i,
  input wire logic s_axil_awvalid_i,
  output logic s_axil_awready_o,
  input wire logic [31:0] s_axil_wdata_i,
  input wire logic [3:0] s_axil_wstrb_i,
  input wire logic s_axil_wvalid_i,
  output logic s_axil_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axil_bresp_o,
  output logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  // AXI4-Lite read
  input wire logic [7:0] s_axil_araddr_i,
  input wire logic s_axil_arvalid_i,
  output logic s_axil_arready_o,
  output logic [31:0] s_axil_rdata_o,
  output logic [1:0] s_axil_rresp_o,
  output logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  // Receiver side
  input wire rgc_pkg::rgc_sample_type sample_i,
  input wire logic packet_done_i,
  input wire logic fifo_empty_i,
  // Front-end controls
  output logic [2:0] lna_gain_code_o,
  output logic lna_impedance_select_o,
  output logic [7:0] current_limit_ma_o,
  output rgc_pkg::rgc_status_type status_o
);
  import rgc_pkg::*;

  // ----------------------------------------------------------------
  // Byte-lane merge used by the configuration registers; band thresholds take wdata bits 7:0 directly
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_band(input logic [7:0] a);
    return a >= ADDR_BAND_THR_BASE && a <= ADDR_BAND_THR_LAST &&
           a[1:0] == 2'b00;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic lna_impedance_select_q;
  logic [2:0] lna_gain_select_a_q;
  logic [3:0] current_limit_trim_q;
  logic rx_enable_q;
  logic continuous_mode_q;
  logic auto_rx_rearm_enable_q;
  logic [7:0] signal_strength_threshold_q;
  logic [15:0] inter_packet_rearm_delay_q;
  logic [NUM_BANDS*8-1:0] band_thr_q;
  logic rx_rearm_request;

  // AXI write and read side state
  logic [7:0] aw_addr_q;
  logic aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rvalid_q;
  logic do_write;
  logic wr_ok;

  // AGC state
  rgc_state_type state_q, state_d;
  logic [1:0] hits_q;
  logic [2:0] agc_gain_q;
  logic [2:0] band_code;
  logic [15:0] delay_cnt_q;
  logic pkt_pend_q;
  logic [7:0] last_strength_q;
  logic sample_hit;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are taken in either order; response follows both
  assign s_axil_awready_o = !aw_have_q && !bvalid_q;
  assign s_axil_wready_o = !w_have_q && !bvalid_q;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign s_axil_bvalid_o = bvalid_q;
  assign s_axil_bresp_o = bresp_q;

  always_comb begin
    unique case (aw_addr_q)
      ADDR_LNA_CONFIG, ADDR_CURRENT_LIMIT, ADDR_RX_CTRL,
      ADDR_SS_THRESHOLD, ADDR_REARM_DELAY, ADDR_STATUS: wr_ok = 1'b1;
      default: wr_ok = is_band(aw_addr_q);
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axil_awvalid_i && s_axil_awready_o) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axil_awaddr_i;
      end
      if (s_axil_wvalid_i && s_axil_wready_o) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axil_wdata_i;
        w_strb_q <= s_axil_wstrb_i;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axil_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [31:0] wval;
  assign wval = merge(32'h0000_0000, w_data_q, w_strb_q);
  logic [31:0] dval;
  assign dval = merge({16'h0000, inter_packet_rearm_delay_q}, w_data_q,
                      w_strb_q);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lna_impedance_select_q <= 1'b0;
      lna_gain_select_a_q <= GAIN_AUTO;
      current_limit_trim_q <= TRIM_RESET;
      rx_enable_q <= 1'b0;
      continuous_mode_q <= 1'b0;
      auto_rx_rearm_enable_q <= 1'b0;
      signal_strength_threshold_q <= SS_THRESHOLD_RESET;
      inter_packet_rearm_delay_q <= REARM_DELAY_RESET;
    end else if (do_write && w_strb_q[0]) begin
      unique case (aw_addr_q)
        ADDR_LNA_CONFIG: begin
          lna_impedance_select_q <= wval[LNA_ZIN_BIT];
          lna_gain_select_a_q <= wval[LNA_SEL_LSB +: 3];
        end
        ADDR_CURRENT_LIMIT: current_limit_trim_q <= wval[3:0];
        ADDR_RX_CTRL: begin
          rx_enable_q <= wval[CTRL_RX_EN_BIT];
          continuous_mode_q <= wval[CTRL_CONT_BIT];
          auto_rx_rearm_enable_q <= wval[CTRL_AUTO_BIT];
        end
        ADDR_SS_THRESHOLD: signal_strength_threshold_q <= wval[7:0];
        ADDR_REARM_DELAY: inter_packet_rearm_delay_q <= dval[15:0];
        default: begin
        end
      endcase
    end else if (do_write && aw_addr_q == ADDR_REARM_DELAY) begin
      inter_packet_rearm_delay_q <= dval[15:0];
    end
  end

  // Band thresholds, one register per band
  genvar g;
  generate
    for (g = 0; g < NUM_BANDS; g++) begin : gen_thr
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          band_thr_q[g*8 +: 8] <= 8'(BAND_THR_RESET_STEP * (g + 1));
        end else if (do_write && w_strb_q[0] &&
                     aw_addr_q == ADDR_BAND_THR_BASE + 8'(4 * g)) begin
          band_thr_q[g*8 +: 8] <= w_data_q[7:0];
        end
      end
    end
  endgenerate

  // Self-clearing: a write of one is a single-cycle request
  assign rx_rearm_request = do_write && w_strb_q[0] &&
                            aw_addr_q == ADDR_RX_CTRL &&
                            w_data_q[CTRL_REARM_BIT];

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign s_axil_arready_o = !rvalid_q;
  assign s_axil_rvalid_o = rvalid_q;
  assign s_axil_rdata_o = rdata_q;
  assign s_axil_rresp_o = rresp_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_axil_arvalid_i && s_axil_arready_o) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      unique case (s_axil_araddr_i)
        ADDR_LNA_CONFIG: begin
          rdata_q[LNA_ZIN_BIT] <= lna_impedance_select_q;
          rdata_q[LNA_SEL_LSB +: 3] <= lna_gain_select_a_q;
          rdata_q[LNA_APPLIED_LSB +: 3] <= lna_gain_code_o;
        end
        ADDR_CURRENT_LIMIT: begin
          rdata_q[3:0] <= current_limit_trim_q;
          rdata_q[LIMIT_MA_LSB +: 8] <= current_limit_ma_o;
        end
        ADDR_RX_CTRL: begin
          rdata_q[CTRL_RX_EN_BIT] <= rx_enable_q;
          rdata_q[CTRL_CONT_BIT] <= continuous_mode_q;
          rdata_q[CTRL_AUTO_BIT] <= auto_rx_rearm_enable_q;
        end
        ADDR_SS_THRESHOLD: rdata_q[7:0] <= signal_strength_threshold_q;
        ADDR_REARM_DELAY: rdata_q[15:0] <= inter_packet_rearm_delay_q;
        ADDR_STATUS: begin
          // Strength reads only once it passes the threshold
          rdata_q[7:0] <= sample_hit_seen() ? last_strength_q : 8'h00;
          rdata_q[STAT_STATE_LSB +: 4] <= state_q;
        end
        default: begin
          if (is_band(s_axil_araddr_i)) begin
            rdata_q[7:0] <= band_thr_q[
              3'(s_axil_araddr_i[4:2] - ADDR_BAND_THR_BASE[4:2])*8 +: 8];
          end else begin
            rresp_q <= RESP_SLVERR;
          end
        end
      endcase
    end else if (rvalid_q && s_axil_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  function automatic logic sample_hit_seen();
    return last_strength_q > signal_strength_threshold_q;
  endfunction

  // ----------------------------------------------------------------
  // Gain loop state machine
  // ----------------------------------------------------------------
  // Threshold must sit at sensitivity or the loop never leaves wait
  assign sample_hit = sample_i.strength >
                      signal_strength_threshold_q;

  rgc_gain_band #(
    .BANDS(NUM_BANDS),
    .WIDTH(8)
  ) u_band (
    .strength_i(sample_i.strength),
    .thresholds_i(band_thr_q),
    .step_code_o(band_code)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (rx_enable_q) state_d = ST_WAIT;
      ST_WAIT: begin
        if (sample_i.valid && sample_hit && hits_q == HITS_NEEDED - 2'h1)
        begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Without auto re-arm the held gain carries over to next packet
        if (!continuous_mode_q && auto_rx_rearm_enable_q &&
            pkt_pend_q && fifo_empty_i) begin
          state_d = ST_DELAY;
        end
      end
      ST_DELAY: if (delay_cnt_q == 16'h0000) state_d = ST_WAIT;
    endcase
    if (rx_rearm_request) state_d = ST_WAIT;
    if (!rx_enable_q) state_d = ST_IDLE;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Consecutive hit counter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hits_q <= 2'h0;
    end else if (state_d != ST_WAIT || state_q != ST_WAIT) begin
      hits_q <= 2'h0;
    end else if (sample_i.valid) begin
      hits_q <= sample_hit ? hits_q + 2'h1 : 2'h0;
    end
  end

  // Gain choice, held until the next selection
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      agc_gain_q <= GAIN_STEP_1;
    end else if (state_q == ST_WAIT && state_d == ST_HOLD) begin
      agc_gain_q <= band_code;
    end
  end

  // Packet-done pending; set by a packet end in hold, cleared in any other state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pkt_pend_q <= 1'b0;
    end else if (packet_done_i && state_q == ST_HOLD) begin
      pkt_pend_q <= 1'b1;
    end else if (state_q != ST_HOLD) begin
      pkt_pend_q <= 1'b0;
    end
  end

  // Inter-packet delay, in clock cycles
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      delay_cnt_q <= 16'h0000;
    end else if (state_d == ST_DELAY && state_q != ST_DELAY) begin
      delay_cnt_q <= inter_packet_rearm_delay_q;
    end else if (state_q == ST_DELAY && delay_cnt_q != 16'h0000) begin
      delay_cnt_q <= delay_cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_strength_q <= 8'h00;
    end else if (sample_i.valid) begin
      last_strength_q <= sample_i.strength;
    end
  end

  // ----------------------------------------------------------------
  // Front-end outputs
  // ----------------------------------------------------------------
  // Reserved code falls back to the loop rather than an unknown gain
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lna_gain_code_o <= GAIN_STEP_1;
      lna_impedance_select_o <= 1'b0;
      current_limit_ma_o <= LIMIT_BASE_MA;
      status_o <= '0;
    end else begin
      if (lna_gain_select_a_q == GAIN_AUTO ||
          lna_gain_select_a_q == GAIN_RESERVED) begin
        lna_gain_code_o <= agc_gain_q;
      end else begin
        lna_gain_code_o <= lna_gain_select_a_q;
      end
      lna_impedance_select_o <= lna_impedance_select_q;
      current_limit_ma_o <= LIMIT_BASE_MA +
        8'(LIMIT_STEP_MA * {4'h0, current_limit_trim_q});
      status_o.waiting <= state_q == ST_WAIT;
      status_o.locked <= state_q == ST_HOLD;
      status_o.gain_step <= agc_gain_q;
    end
  end

endmodule

// >>> testbench/rgc_agc_monitor.sv
// Checker for the gain control top: bus handshakes and AGC outputs.
// Assumes it is bound to the top and sees only its ports.
`timescale 1ns/1ps
module rgc_agc_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register bus
  input wire logic s_axil_awvalid_i,
  input wire logic s_axil_awready_o,
  input wire logic s_axil_wvalid_i,
  input wire logic s_axil_wready_o,
  input wire logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  input wire logic s_axil_arready_o,
  input wire logic [31:0] s_axil_rdata_o,
  input wire logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  // Receiver side and front-end outputs
  input wire rgc_pkg::rgc_sample_type sample_i,
  input wire logic [2:0] lna_gain_code_o,
  input wire logic [7:0] current_limit_ma_o,
  input wire rgc_pkg::rgc_status_type status_o
);
  import rgc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ------------------------------------------------------------
  // Front-end outputs
  // ------------------------------------------------------------
  sequence s_lock;
    $rose(status_o.locked);
  endsequence
  property p_limit;
    current_limit_ma_o >= 8'h2d && current_limit_ma_o <= 8'h78 &&
      (current_limit_ma_o - 8'h2d) % 8'h05 == 8'h00;
  endproperty
  a_limit: assert property (p_limit)
    else $error("current limit off the 5 mA grid");
  property p_gain_range;
    lna_gain_code_o inside {[3'h1:3'h6]};
  endproperty
  a_gain_range: assert property (p_gain_range)
    else $error("gain code outside steps 1 to 6");
  // Lock needs a qualifying sample two edges earlier
  property p_lock_cause;
    s_lock |-> $past(sample_i.valid, 2);
  endproperty
  a_lock_cause: assert property (p_lock_cause)
    else $error("lock without a sample");
  property p_held;
    status_o.locked && $past(status_o.locked) |-> $stable(lna_gain_code_o);
  endproperty
  a_held: assert property (p_held)
    else $error("gain moved while locked");
  // ------------------------------------------------------------
  // Bus handshakes
  // ------------------------------------------------------------
  property p_bresp_time;
    s_axil_awvalid_i && s_axil_awready_o && s_axil_wvalid_i &&
      s_axil_wready_o |-> ##2 s_axil_bvalid_o;
  endproperty
  a_bresp_time: assert property (p_bresp_time)
    else $error("write response late");
  property p_bhold;
    s_axil_bvalid_o && !s_axil_bready_i |=> s_axil_bvalid_o;
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
  property p_rhold;
    s_axil_rvalid_o && !s_axil_rready_i |=>
      s_axil_rvalid_o && $stable(s_axil_rdata_o);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped or changed");
  property p_arready;
    s_axil_arready_o == !s_axil_rvalid_o;
  endproperty
  a_arready: assert property (p_arready)
    else $error("read address ready wrong");
endmodule

// >>> testbench/rgc_host_model.sv
// Host controller model: one AXI4-Lite write and one read at a time.
// Assumes the slave answers in its own time; the bench cuts hangs.
`timescale 1ns/1ps
module rgc_host_model (
  // Clock
  input wire logic clk_i,
  // Write channels
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  // Read channels
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  initial begin
    {awaddr_o, araddr_o, wdata_o, wstrb_o} = '0;
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
  end
  // Released address and data lines show the inverse and strobes go to zero, never the stale value
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_i);
    {awaddr_o, wdata_o, wstrb_o} <= {a, d, 4'hf};
    {awvalid_o, wvalid_o, bready_o} <= 3'h7;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) begin
        aw_ok = 1'b1;
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wvalid_o && wready_i) begin
        w_ok = 1'b1;
        wvalid_o <= 1'b0;
        {wdata_o, wstrb_o} <= {~d, 4'h0};
      end
    end
    while (!bvalid_i) @(posedge clk_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_i);
    {araddr_o, arvalid_o, rready_o} <= {a, 2'h3};
    do @(posedge clk_i); while (!arready_i);
    {araddr_o, arvalid_o} <= {~a, 1'b0};
    do @(posedge clk_i); while (!rvalid_i);
    {d, r} = {rdata_i, rresp_i};
    rready_o <= 1'b0;
  endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the gain control top with a host model.
// Assumes the band thresholds keep their reset values.
`timescale 1ns/1ps
module testbench;
  import rgc_pkg::*;
  logic clk_i, rstn_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, done, empty, zin;
  logic [7:0] awaddr, araddr, limit, lim;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [2:0] gain;
  rgc_sample_type sample_i;
  rgc_status_type status_o;
  int err_total, samples_checked, cycles;
  logic [7:0] lvl [6] = '{8'h20, 8'h50, 8'h80, 8'ha0, 8'hd0, 8'hff};
  rgc_agc_top u_rgc_agc_top (.clk_i(clk_i), .rstn_i(rstn_i),
    .s_axil_awaddr_i(awaddr), .s_axil_awvalid_i(awvalid),
    .s_axil_awready_o(awready), .s_axil_wdata_i(wdata),
    .s_axil_wstrb_i(wstrb), .s_axil_wvalid_i(wvalid),
    .s_axil_wready_o(wready), .s_axil_bresp_o(bresp),
    .s_axil_bvalid_o(bvalid), .s_axil_bready_i(bready),
    .s_axil_araddr_i(araddr), .s_axil_arvalid_i(arvalid),
    .s_axil_arready_o(arready), .s_axil_rdata_o(rdata),
    .s_axil_rresp_o(rresp), .s_axil_rvalid_o(rvalid),
    .s_axil_rready_i(rready), .sample_i(sample_i),
    .packet_done_i(done), .fifo_empty_i(empty),
    .lna_gain_code_o(gain), .lna_impedance_select_o(zin),
    .current_limit_ma_o(limit), .status_o(status_o));
  rgc_host_model u_rgc_host_model (.clk_i(clk_i), .awaddr_o(awaddr),
    .awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata),
    .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
    .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
    .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid),
    .rready_o(rready));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    u_rgc_host_model.wr(a, v, r);
    chk("bresp", 32'(RESP_OKAY), 32'(r));
  endtask
  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e, m, input logic [1:0] er);
    u_rgc_host_model.rd(a, d, r);
    chk(n, e & m, d & m);
    chk("rresp", 32'(er), 32'(r));
  endtask
  task automatic hit(input logic [7:0] s);
    @(posedge clk_i);
    sample_i <= {1'b1, s};
    @(posedge clk_i);
    sample_i.valid <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop;
    end
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {err_total, samples_checked, cycles} = '0;
    {rstn_i, done, empty} = 3'h0;
    sample_i = '0;
    ticks(12);
    rstn_i <= 1'b1;
    rdc("limit_rst", ADDR_CURRENT_LIMIT, 32'h5f0a, 32'hff0f, RESP_OKAY);
    rdc("thr_rst", ADDR_SS_THRESHOLD, 32'he4, 32'hff, RESP_OKAY);
    rdc("unmapped", 8'h40, 32'h0, 32'hffffffff, RESP_SLVERR);
    u_rgc_host_model.wr(8'h40, 32'hffffffff, r);
    chk("bresp_unmapped", 32'(RESP_SLVERR), 32'(r));
    for (int t = 0; t < 16; t++) begin
      wr(ADDR_CURRENT_LIMIT, 32'(t));
      lim = 8'h2d + 8'(t) * 8'h05;
      rdc("limit", ADDR_CURRENT_LIMIT, {16'h0, lim, 4'h0, 4'(t)},
          32'hff0f, RESP_OKAY);
      chk("limit_pin", 32'(lim), 32'(limit));
    end
    for (int g = 1; g < 8; g++) begin
      wr(ADDR_LNA_CONFIG, {28'h0, 3'(g), 1'(g % 2)});
      ticks(3);
      chk("gain_pin", g == 7 ? 32'h1 : 32'(g), 32'(gain));
      chk("zin_pin", 32'(g % 2), 32'(zin));
    end
    wr(ADDR_LNA_CONFIG, 32'h0);
    wr(ADDR_SS_THRESHOLD, 32'h10);
    wr(ADDR_RX_CTRL, 32'h1);
    hit(8'h50);
    hit(8'h08);
    hit(8'h50);
    ticks(4);
    chk("still_waiting", 32'h1, 32'(status_o.waiting));
    hit(8'h50);
    ticks(4);
    chk("locked", 32'h1, 32'(status_o.locked));
    chk("gain_auto", 32'h2, 32'(gain));
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_RX_CTRL, 32'h9);
      ticks(2);
      chk("rearm_wait", 32'h1, 32'(status_o.waiting));
      hit(lvl[i]);
      hit(lvl[i]);
      ticks(4);
      chk("band_gain", 32'(i + 1), 32'(gain));
      chk("step_stat", 32'(i + 1), 32'(status_o.gain_step));
      rdc("applied", ADDR_LNA_CONFIG, 32'(i + 1) << 4, 32'h70,
          RESP_OKAY);
    end
    // Packet mode without auto re-arm keeps the gain
    empty <= 1'b1;
    @(posedge clk_i) done <= 1'b1;
    @(posedge clk_i) done <= 1'b0;
    hit(8'h20);
    hit(8'h20);
    ticks(20);
    chk("kept_lock", 32'h1, 32'(status_o.locked));
    chk("kept_gain", 32'h6, 32'(gain));
    wr(ADDR_REARM_DELAY, 32'h5);
    empty <= 1'b0;
    wr(ADDR_RX_CTRL, 32'h5);
    @(posedge clk_i) done <= 1'b1;
    @(posedge clk_i) done <= 1'b0;
    ticks(10);
    chk("fifo_full_hold", 32'h1, 32'(status_o.locked));
    empty <= 1'b1;
    ticks(3);
    chk("in_delay", 32'h0, 32'(status_o.waiting));
    chk("left_hold", 32'h0, 32'(status_o.locked));
    ticks(12);
    chk("auto_rearm", 32'h1, 32'(status_o.waiting));
    wr(ADDR_RX_CTRL, 32'h7);
    hit(8'h80);
    hit(8'h80);
    done <= 1'b1;
    @(posedge clk_i) done <= 1'b0;
    ticks(20);
    chk("cont_keep", 32'h1, 32'(status_o.locked));
    wr(ADDR_RX_CTRL, 32'hf);
    ticks(2);
    chk("cont_rearm", 32'h1, 32'(status_o.waiting));
    wr(ADDR_RX_CTRL, 32'h0);
    rdc("idle", ADDR_STATUS, 32'h180, 32'hfff, RESP_OKAY);
    report_and_stop;
  end
endmodule
bind rgc_agc_top rgc_agc_monitor u_rgc_agc_monitor (.clk_i(clk_i),
  .rstn_i(rstn_i), .s_axil_awvalid_i(s_axil_awvalid_i),
  .s_axil_awready_o(s_axil_awready_o),
  .s_axil_wvalid_i(s_axil_wvalid_i), .s_axil_wready_o(s_axil_wready_o),
  .s_axil_bvalid_o(s_axil_bvalid_o), .s_axil_bready_i(s_axil_bready_i),
  .s_axil_arready_o(s_axil_arready_o), .s_axil_rdata_o(s_axil_rdata_o),
  .s_axil_rvalid_o(s_axil_rvalid_o), .s_axil_rready_i(s_axil_rready_i),
  .sample_i(sample_i), .lna_gain_code_o(lna_gain_code_o),
  .current_limit_ma_o(current_limit_ma_o), .status_o(status_o));
